// ### dpt_top.sv
/*
 * Debug probe external trigger block: APB registers, two input
 * channels that halt the user program, two output pulse channels
 * fired when the program stops, and a level interrupt.
 * Assumes PROG_STOPPED is a level synchronous to SYS_CLK and that
 * the core halts while HALT_REQ is high.
 */
module dpt_top (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Trigger lines
    input wire logic [1:0] TRIG_IN,
    output logic [1:0] TRIG_OUT,
    // Core handshake
    input wire logic PROG_STOPPED,
    output logic HALT_REQ,
    // Interrupt
    output logic IRQ
);
    // -------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // -------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------
    logic [1:0] in_en;
    logic [1:0] out_en;
    dpt_pkg::dpt_mode_e mode [dpt_pkg::N_CH];
    logic [15:0] width [dpt_pkg::N_CH];
    logic [dpt_pkg::ST_W-1:0] status;
    logic [dpt_pkg::ST_W-1:0] mask;
    logic [1:0] hit;
    logic [1:0] level;
    logic [1:0] done;
    logic stop_prev;
    logic stop_rise;
    logic wr_en;
    logic rd_setup;
    logic [dpt_pkg::ST_W-1:0] events;
    dpt_pkg::dpt_in_cfg_s in_cfg [dpt_pkg::N_CH];
    dpt_pkg::dpt_out_cfg_s out_cfg [dpt_pkg::N_CH];

    // -------------------------------------------------------------
    // Address decode helpers
    // -------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = a == dpt_pkg::CTRL_OFF || a == dpt_pkg::WIDTH0_OFF ||
            a == dpt_pkg::WIDTH1_OFF || a == dpt_pkg::STATUS_OFF ||
            a == dpt_pkg::MASK_OFF || a == dpt_pkg::STATE_OFF;
    endfunction : addr_ok

    // Width zero is outside the legal range, so it is held as one
    function automatic logic [15:0] clamp_width(input logic [15:0] w);
        clamp_width = (w == 16'h0000) ? 16'h0001 : w;
    endfunction : clamp_width

    function automatic logic [31:0] ctrl_word();
        logic [31:0] w;
        w = 32'h00000000;
        w[dpt_pkg::IN_EN_POS +: 2] = in_en;
        w[dpt_pkg::OUT_EN_POS +: 2] = out_en;
        for (int i = 0; i < dpt_pkg::N_CH; i++) begin
            w[dpt_pkg::MODE_POS + i * dpt_pkg::MODE_STRIDE +: 3] = mode[i];
        end
        ctrl_word = w;
    endfunction : ctrl_word

    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            dpt_pkg::CTRL_OFF: w = ctrl_word();
            dpt_pkg::WIDTH0_OFF: w[15:0] = width[0];
            dpt_pkg::WIDTH1_OFF: w[15:0] = width[1];
            dpt_pkg::STATUS_OFF: w[dpt_pkg::ST_W-1:0] = status;
            dpt_pkg::MASK_OFF: w[dpt_pkg::ST_W-1:0] = mask;
            dpt_pkg::STATE_OFF: begin
                w[dpt_pkg::LVL_POS +: 2] = level;
                w[dpt_pkg::PULSE_POS +: 2] = TRIG_OUT;
            end
            default: w = 32'h00000000;
        endcase
        read_word = w;
    endfunction : read_word

    // -------------------------------------------------------------
    // APB slave, zero wait states
    // -------------------------------------------------------------
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok(PADDR);
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h00000000;
        end else if (rd_setup) begin
            PRDATA <= read_word(PADDR);
        end
    end

    // Control register
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            in_en <= 2'h0;
            out_en <= 2'h0;
            for (int i = 0; i < dpt_pkg::N_CH; i++) begin
                mode[i] <= dpt_pkg::MODE_RISE;
            end
        end else if (wr_en && PADDR == dpt_pkg::CTRL_OFF) begin
            in_en <= PWDATA[dpt_pkg::IN_EN_POS +: 2];
            out_en <= PWDATA[dpt_pkg::OUT_EN_POS +: 2];
            for (int i = 0; i < dpt_pkg::N_CH; i++) begin
                mode[i] <= dpt_pkg::dpt_mode_e'(
                    PWDATA[dpt_pkg::MODE_POS + i * dpt_pkg::MODE_STRIDE +: 3]);
            end
        end
    end

    // Pulse width registers
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            width[0] <= dpt_pkg::WIDTH_RST;
            width[1] <= dpt_pkg::WIDTH_RST;
        end else if (wr_en && PADDR == dpt_pkg::WIDTH0_OFF) begin
            width[0] <= clamp_width(PWDATA[15:0]);
        end else if (wr_en && PADDR == dpt_pkg::WIDTH1_OFF) begin
            width[1] <= clamp_width(PWDATA[15:0]);
        end
    end

    // Interrupt mask
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mask <= dpt_pkg::MASK_RST;
        end else if (wr_en && PADDR == dpt_pkg::MASK_OFF) begin
            mask <= PWDATA[dpt_pkg::ST_W-1:0];
        end
    end

    // -------------------------------------------------------------
    // Input channels, numbered by instance and never remapped
    // -------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < dpt_pkg::N_CH; i++) begin
            in_cfg[i].en = in_en[i];
            in_cfg[i].mode = mode[i];
            out_cfg[i].en = out_en[i];
            out_cfg[i].width = width[i];
        end
    end

    dpt_trig_in u_in0 (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .cfg(in_cfg[0]),
        .trig(TRIG_IN[0]),
        .level(level[0]),
        .hit(hit[0])
    );

    dpt_trig_in u_in1 (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .cfg(in_cfg[1]),
        .trig(TRIG_IN[1]),
        .level(level[1]),
        .hit(hit[1])
    );

    // Halt is not configurable: any hit requests it
    assign HALT_REQ = |hit;

    // -------------------------------------------------------------
    // Output channels, fired by the stop of the user program
    // -------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            stop_prev <= 1'b0;
        end else begin
            stop_prev <= PROG_STOPPED;
        end
    end

    assign stop_rise = PROG_STOPPED && !stop_prev;

    dpt_trig_out u_out0 (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .cfg(out_cfg[0]),
        .fire(stop_rise),
        .pulse(TRIG_OUT[0]),
        .done(done[0])
    );

    dpt_trig_out u_out1 (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .cfg(out_cfg[1]),
        .fire(stop_rise),
        .pulse(TRIG_OUT[1]),
        .done(done[1])
    );

    // -------------------------------------------------------------
    // Interrupt status, write one to clear, set wins over clear
    // -------------------------------------------------------------
    always_comb begin
        events = '0;
        events[dpt_pkg::ST_IN_POS +: 2] = hit;
        events[dpt_pkg::ST_STOP_POS] = stop_rise;
        events[dpt_pkg::ST_DONE_POS +: 2] = done;
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else if (wr_en && PADDR == dpt_pkg::STATUS_OFF) begin
            status <= (status & ~PWDATA[dpt_pkg::ST_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    // Level output, kept high until software clears or masks
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status & mask);
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    halt_on_high_a: assert property (
        (in_en[0] && mode[0] == dpt_pkg::MODE_HIGH && TRIG_IN[0])
        ##1 (in_en[0] && mode[0] == dpt_pkg::MODE_HIGH) [*2]
        |=> HALT_REQ) else $error("high trigger did not halt");

    no_halt_off_a: assert property (
        (in_en == 2'h0) [*2] |=> !HALT_REQ)
        else $error("halt with both inputs disabled");

    stop_pulse_a: assert property (
        (out_en[1] && !TRIG_OUT[1] && stop_rise) ##1 out_en[1]
        |-> TRIG_OUT[1]) else $error("stop did not fire output");

    width_min_a: assert property (
        width[0] != 16'h0000 && width[1] != 16'h0000)
        else $error("pulse width below one");

    high_mode_a: assert property (
        (in_en[1] && mode[1] == dpt_pkg::MODE_HIGH && level[1])
        |=> hit[1]) else $error("high level missed");

    status_keep_a: assert property (
        ($rose(status[dpt_pkg::ST_STOP_POS])) |->
        $past(stop_rise)) else $error("stop flag without stop");

    halt_seen_c: cover property (HALT_REQ);
    both_edge_c: cover property (
        in_en[0] && mode[0] == dpt_pkg::MODE_BOTH && hit[0]);
    irq_seen_c: cover property (IRQ);
    out_pulse_c: cover property ($rose(TRIG_OUT[0]));
endmodule : dpt_top

// ### dpt_pkg.sv
/*
 * Constants and types shared by the debug probe external trigger block.
 * Assumes a single 200 MHz clock and an APB master for configuration.
 */
// Function
// - Two input, two output channels, fixed numbering
// - Input enable per channel, default off
// - Edge mode: rising, falling or both
// - High level mode triggers on high
// - Low level mode triggers on low
// - Input trigger always halts user program
// - Output enable per channel, default off
// - One high pulse when program stops
// - Pulse width 1 to 65535 us, default 1
package dpt_pkg;
    // -------------------------------------------------------------
    // Sizes and timing
    // -------------------------------------------------------------
    localparam int N_CH = 2;
    localparam int CLK_NS = 5;
    localparam int US_NS = 1000;
    localparam logic [7:0] US_CYCLES = 8'(US_NS / CLK_NS);
    // -------------------------------------------------------------
    // Register offsets, fields and reset values
    // -------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] WIDTH0_OFF = 8'h04;
    localparam logic [7:0] WIDTH1_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0C;
    localparam logic [7:0] MASK_OFF = 8'h10;
    localparam logic [7:0] STATE_OFF = 8'h14;
    localparam int IN_EN_POS = 0;
    localparam int OUT_EN_POS = 4;
    localparam int MODE_POS = 8;
    localparam int MODE_STRIDE = 4;
    localparam int ST_IN_POS = 0;
    localparam int ST_STOP_POS = 2;
    localparam int ST_DONE_POS = 3;
    localparam int ST_W = 5;
    localparam int LVL_POS = 0;
    localparam int PULSE_POS = 4;
    localparam logic [15:0] WIDTH_RST = 16'h0001;
    localparam logic [ST_W-1:0] MASK_RST = 5'h00;
    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RISE = 3'h0,
        MODE_FALL = 3'h1,
        MODE_BOTH = 3'h2,
        MODE_HIGH = 3'h3,
        MODE_LOW = 3'h4
    } dpt_mode_e;
    typedef struct packed {
        logic en;
        dpt_mode_e mode;
    } dpt_in_cfg_s;
    typedef struct packed {
        logic en;
        logic [15:0] width;
    } dpt_out_cfg_s;
endpackage : dpt_pkg

// ### dpt_trig_in.sv
/*
 * One trigger input channel: synchroniser and edge or level detector.
 * Assumes trig may change at any time; rst_n is already synchronised.
 */
module dpt_trig_in (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire dpt_pkg::dpt_in_cfg_s cfg,
    // Line and result
    input wire logic trig,
    output logic level,
    output logic hit
);
    logic meta;
    logic prev;

    // -------------------------------------------------------------
    // Synchroniser, meta read only by level
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= trig;
            level <= meta;
            prev <= level;
        end
    end

    // -------------------------------------------------------------
    // Detector, gated by enable
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit <= 1'b0;
        end else if (!cfg.en) begin
            hit <= 1'b0;
        end else begin
            case (cfg.mode)
                dpt_pkg::MODE_RISE: hit <= level & ~prev;
                dpt_pkg::MODE_FALL: hit <= ~level & prev;
                dpt_pkg::MODE_BOTH: hit <= level ^ prev;
                dpt_pkg::MODE_HIGH: hit <= level;
                dpt_pkg::MODE_LOW: hit <= ~level;
                default: hit <= 1'b0;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    off_quiet_a: assert property (!cfg.en |=> !hit)
        else $error("disabled input raised a hit");
    rise_seen_a: assert property (
        (cfg.en && cfg.mode == dpt_pkg::MODE_RISE && level && !prev)
        |=> hit) else $error("rising edge missed");
    low_seen_a: assert property (
        (cfg.en && cfg.mode == dpt_pkg::MODE_LOW && !level) |=> hit)
        else $error("low level missed");
    sync_delay_a: assert property (level == $past(trig, 2))
        else $error("synchroniser delay wrong");
endmodule : dpt_trig_in

// ### dpt_trig_out.sv
/*
 * One trigger output channel: high pulse timed in microseconds.
 * Assumes fire is a one-cycle pulse; rst_n is already synchronised.
 */
module dpt_trig_out (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration and event
    input wire dpt_pkg::dpt_out_cfg_s cfg,
    input wire logic fire,
    // Pulse
    output logic pulse,
    output logic done
);
    logic [7:0] sub;
    logic [15:0] us_left;
    logic us_tick;

    // Microsecond enable from a divider restarted with each pulse
    assign us_tick = pulse && sub == dpt_pkg::US_CYCLES - 8'h01;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub <= 8'h00;
        end else if (!pulse || us_tick) begin
            sub <= 8'h00;
        end else begin
            sub <= sub + 8'h01;
        end
    end

    // -------------------------------------------------------------
    // Pulse; a new stop during a pulse is not stretched
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse <= 1'b0;
            us_left <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!cfg.en) begin
                pulse <= 1'b0;
            end else if (fire && !pulse) begin
                pulse <= 1'b1;
                us_left <= cfg.width;
            end else if (us_tick) begin
                us_left <= us_left - 16'h0001;
                if (us_left == 16'h0001) begin
                    pulse <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    logic [23:0] run_len;
    logic [15:0] width_lat;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_len <= 24'h000000;
            width_lat <= 16'h0000;
        end else begin
            run_len <= pulse ? run_len + 24'h000001 : 24'h000000;
            if (fire && !pulse) width_lat <= cfg.width;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    out_off_a: assert property (!cfg.en |=> !pulse)
        else $error("disabled output pulsed");
    pulse_start_a: assert property (
        (cfg.en && fire && !pulse) |=> pulse)
        else $error("pulse did not start on stop");
    pulse_width_a: assert property (
        ($fell(pulse) && done) |->
        run_len == 24'(width_lat) * 24'(dpt_pkg::US_CYCLES))
        else $error("pulse width wrong");
    pulse_done_c: cover property ($fell(pulse) && run_len > 24'h0000C7);
endmodule : dpt_trig_out

// ### dpt_equip.sv
/*
 * Behavioural model of the test equipment on the trigger lines.
 * Assumes the bench asks for line levels; lines move only at clock edges.
 */
module dpt_equip (
    // Clock
    input wire logic clk,
    // Requested levels and driven lines
    input wire logic [1:0] lvl_req,
    output logic [1:0] line,
    // Pulses sampled and their measurements
    input wire logic [1:0] pulse,
    output logic [1:0][31:0] width,
    output logic [1:0][7:0] count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0][31:0] run;
    // ---------------------------------------------------------
    // Line drive
    // ---------------------------------------------------------
    initial begin
        line = 2'h0;
        width = '0;
        count = '0;
        run = '0;
    end
    // Levels are held between requests, so the detector sees them
    always @(posedge clk) begin
        line <= lvl_req;
    end
    // ---------------------------------------------------------
    // Pulse measurement in clock cycles
    // ---------------------------------------------------------
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (pulse[i] === 1'b1) begin
                run[i] <= run[i] + 32'h1;
            end else if (run[i] != 32'h0) begin
                width[i] <= run[i];
                count[i] <= count[i] + 8'h1;
                run[i] <= 32'h0;
            end
        end
    end
endmodule : dpt_equip

// ### tb_dpt_top.sv
/*
 * Self-checking bench of the external trigger block.
 * Assumes the APB map of the package and a 200 MHz clock.
 */
module tb_dpt_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, nrst, psel, penable, pwrite, stop, halt_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic pready, pslverr, halt_req, irq;
    logic [1:0] trig_in, trig_out, lvl;
    logic [1:0][31:0] width;
    logic [1:0][7:0] count;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    // ---------------------------------------------------------
    // Clock, design and equipment
    // ---------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    dpt_top dut (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TRIG_IN(trig_in), .TRIG_OUT(trig_out),
        .PROG_STOPPED(stop), .HALT_REQ(halt_req), .IRQ(irq));
    dpt_equip equip (.clk(sys_clk), .lvl_req(lvl), .line(trig_in),
        .pulse(trig_out), .width(width), .count(count));
    always @(posedge sys_clk) begin
        if (halt_req === 1'b1) halt_seen <= 1'b1;
    end
    // Hang guard, well above the few thousand cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end
    // ---------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr
    function automatic logic exp_hit(input logic [2:0] m,
                                     input logic a, input logic b);
        case (m)
            dpt_pkg::MODE_RISE: return !a && b;
            dpt_pkg::MODE_FALL: return a && !b;
            dpt_pkg::MODE_BOTH: return a ^ b;
            dpt_pkg::MODE_HIGH: return b;
            dpt_pkg::MODE_LOW: return !b;
            default: return 1'b0;
        endcase
    endfunction : exp_hit
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Ends at the first edge with pready high; the hang guard ends it otherwise
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask : wr
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // ---------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic e, a, h;
        logic [1:0] v;
        logic [2:0] m;
        logic [15:0] w0, w1, we1;
        logic [7:0] c0, c1;
        nrst = 1'b0;
        {psel, penable, pwrite, stop, halt_seen} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        lvl = 2'h0;
        rnd = 32'h0001776D;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(0, dpt_pkg::CTRL_OFF, 0, d, e);
        chk("ctrl reset", d, 32'h0);
        apb(0, dpt_pkg::WIDTH0_OFF, 0, d, e);
        chk("width0 reset", d, 32'h1);
        apb(0, dpt_pkg::WIDTH1_OFF, 0, d, e);
        chk("width1 reset", d, 32'h1);
        apb(0, dpt_pkg::MASK_OFF, 0, d, e);
        chk("mask reset", d, 32'h0);
        apb(0, 8'h1A, 0, d, e);
        chk("unmapped err", 32'(e), 32'h1);
        chk("unmapped data", d, 32'h0);
        chk("ready", 32'(pready), 32'h1);
        // Disabled inputs see both levels and edges
        lvl <= 2'h3;
        repeat (8) @(posedge sys_clk);
        lvl <= 2'h0;
        repeat (8) @(posedge sys_clk);
        apb(0, dpt_pkg::STATUS_OFF, 0, d, e);
        chk("disabled status", d, 32'h0);
        chk("disabled halt", 32'(halt_seen), 32'h0);
        // Every detection mode on both fixed channels
        for (int ch = 0; ch < 2; ch++) begin
            for (int mi = 0; mi < 5; mi++) begin
                rnd = lfsr(rnd);
                a = rnd[0];
                m = 3'(mi);
                v = rnd[2:1];
                v[ch] = a;
                @(posedge sys_clk);
                lvl <= v;
                repeat (4) @(posedge sys_clk);
                wr(dpt_pkg::CTRL_OFF, (32'h1 << ch) |
                   (32'(m) << (dpt_pkg::MODE_POS + dpt_pkg::MODE_STRIDE * ch)));
                repeat (6) @(posedge sys_clk);
                wr(dpt_pkg::STATUS_OFF, 32'h1F);
                @(posedge sys_clk);
                #1 halt_seen = 1'b0;
                v[ch] = !a;
                @(posedge sys_clk);
                lvl <= v;
                repeat (8) @(posedge sys_clk);
                h = exp_hit(m, a, a) | exp_hit(m, a, !a);
                apb(0, dpt_pkg::STATUS_OFF, 0, d, e);
                chk("hit status", d & 32'h3, 32'(h) << ch);
                chk("halt", 32'(halt_seen), 32'(h));
            end
        end
        // Output pulses, one of them disabled in the second round
        for (int r = 0; r < 2; r++) begin
            rnd = lfsr(rnd);
            w0 = 16'(rnd[3:0] % 3 + 1);
            w1 = (r == 1) ? 16'h0 : 16'(rnd[7:4] % 3 + 1);
            we1 = (w1 == 16'h0) ? 16'h1 : w1;
            wr(dpt_pkg::WIDTH0_OFF, 32'(w0));
            wr(dpt_pkg::WIDTH1_OFF, 32'(w1));
            apb(0, dpt_pkg::WIDTH1_OFF, 0, d, e);
            chk("width1", d, 32'(we1));
            wr(dpt_pkg::CTRL_OFF, (r == 1) ? 32'h10 : 32'h30);
            wr(dpt_pkg::STATUS_OFF, 32'h1F);
            c0 = count[0];
            c1 = count[1];
            @(posedge sys_clk);
            stop <= 1'b1;
            @(posedge sys_clk);
            #1 chk("pulse start", 32'(trig_out), (r == 1) ? 1 : 3);
            apb(0, dpt_pkg::STATE_OFF, 0, d, e);
            chk("state", d, ((r == 1) ? 32'h10 : 32'h30) | 32'(lvl));
            // Stop held past the pulse: still a single pulse
            repeat (800) @(posedge sys_clk);
            stop <= 1'b0;
            @(posedge sys_clk);
            chk("count0", 32'(count[0] - c0), 32'h1);
            chk("width0", width[0], 32'(w0) * 32'(dpt_pkg::US_CYCLES));
            chk("count1", 32'(count[1] - c1), 32'(1 - r));
            if (r == 0) begin
                chk("width1", width[1], 32'(w1) * 32'(dpt_pkg::US_CYCLES));
            end
            apb(0, dpt_pkg::STATUS_OFF, 0, d, e);
            chk("stop status", d, (r == 1) ? 32'h0C : 32'h1C);
        end
        // Interrupt raised, cleared and masked
        chk("irq masked", 32'(irq), 32'h0);
        wr(dpt_pkg::MASK_OFF, 32'h04);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 32'(irq), 32'h1);
        wr(dpt_pkg::STATUS_OFF, 32'h04);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'(irq), 32'h0);
        wr(dpt_pkg::MASK_OFF, 32'h08);
        repeat (2) @(posedge sys_clk);
        chk("irq other", 32'(irq), 32'h1);
        wr(dpt_pkg::MASK_OFF, 32'h00);
        repeat (2) @(posedge sys_clk);
        chk("irq off", 32'(irq), 32'h0);
        wr(dpt_pkg::STATE_OFF, 32'hFFFFFFFF);
        apb(0, dpt_pkg::STATE_OFF, 0, d, e);
        chk("state ro", d, 32'(lvl));
        wrap_up();
    end
endmodule : tb_dpt_top
